// >>> hw/asr_consts.vh
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// geometry
`define ASR_ADDR_W 16
`define ASR_DATA_W 4
// clock period in ps
`define ASR_CLK_PS 10000
// slowest speed grade minimum and maximum times, in ps
`define ASR_WRITE_CYCLE_PS 12000
`define ASR_ADDR_TO_WRITE_END_MIN_PS 10000
`define ASR_DATA_TO_WRITE_END_MIN_PS 6000
`define ASR_WRITE_HIZ_MAX_PS 6000
`define ASR_READ_ACCESS_MAX_PS 12000
`define ASR_READ_CYCLE_PS 12000
// derived cycle counts, least times rounded up
`define ASR_CYC_UP(ps) (((ps) + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_WR_LOW_CYC `ASR_CYC_UP(`ASR_ADDR_TO_WRITE_END_MIN_PS)
`define ASR_HIZ_CYC `ASR_CYC_UP(`ASR_WRITE_HIZ_MAX_PS)
`define ASR_RD_WAIT_CYC (`ASR_CYC_UP(`ASR_READ_ACCESS_MAX_PS) + 1)
`define ASR_DATA_CYC `ASR_CYC_UP(`ASR_DATA_TO_WRITE_END_MIN_PS)
// cycles the data input filter needs before its value settles
`define ASR_FILT_CYC 3
`define ASR_CNT_W 4
`endif

// >>> hw/asr_sync.v
`timescale 1ns/1ps
`include "asr_consts.vh"
// three-stage input filter: a change counts once stages two and three agree
module asr_sync (
  // clock and reset
  input wire clk,
  input wire srst,
  // pins
  input wire [`ASR_DATA_W-1:0] pin,
  output reg [`ASR_DATA_W-1:0] value
);
  reg [`ASR_DATA_W-1:0] s1;
  reg [`ASR_DATA_W-1:0] s2;
  reg [`ASR_DATA_W-1:0] s3;
  integer i;
  always @(posedge clk) begin
    if (srst) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      value <= 4'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < `ASR_DATA_W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          value[i] <= s3[i];
        end
      end
    end
  end
endmodule // asr_sync

// >>> hw/asr_host.v
`timescale 1ns/1ps
`include "asr_consts.vh"
// Functional notes
// - host keeps the write strobe high during every read.
// - read cycle spans from last valid address bit to first changing one.
// - write cycle lasts at least 8, 10 or 12 ns by speed grade.
// - address stable 8, 9 or 10 ns before strobe rises; set by strobe fall.
// - select low at least 7, 8 or 9 ns before write end.
// - write data valid 4, 5 or 6 ns before write end; may drop at end.
// - host meets minimum times; memory answers within maximum times.
// - host avoids driving the data bus while the memory drives it.
module asr_host (
  // clock and reset
  input wire clk,
  input wire srst,
  // user request
  input wire req_valid,
  input wire req_write,
  input wire [`ASR_ADDR_W-1:0] req_addr,
  input wire [`ASR_DATA_W-1:0] req_wdata,
  output reg req_ready,
  // user answer
  output reg rsp_valid,
  output reg [`ASR_DATA_W-1:0] rsp_rdata,
  // memory pins
  output reg [`ASR_ADDR_W-1:0] addr_in,
  output reg chip_select_n,
  output reg write_strobe_n,
  output reg output_enable_n,
  input wire [`ASR_DATA_W-1:0] data_io_in,
  output reg [`ASR_DATA_W-1:0] data_io_out,
  output reg data_io_oe
);
  // one-hot states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_WSET = 6'h02;
  localparam [5:0] ST_WLOW = 6'h04;
  localparam [5:0] ST_WEND = 6'h08;
  localparam [5:0] ST_RD = 6'h10;
  localparam [5:0] ST_REND = 6'h20;
  localparam [`ASR_CNT_W-1:0] ZERO = 4'h0;
  localparam [`ASR_CNT_W-1:0] ONE = 4'h1;

  // cut a cycle figure to the counter width on purpose
  function [`ASR_CNT_W-1:0] to_cnt;
    input integer n;
    begin
      to_cnt = n[`ASR_CNT_W-1:0];
    end
  endfunction

  // one step down, shared by every waiting state
  function [`ASR_CNT_W-1:0] cnt_dec;
    input [`ASR_CNT_W-1:0] c;
    begin
      cnt_dec = c - ONE;
    end
  endfunction

  // cycle counts; each minimum time rounds up to whole clocks
  localparam integer WR_LOW_I = `ASR_WR_LOW_CYC;
  localparam integer HIZ_I = `ASR_HIZ_CYC;
  localparam integer DATA_I = `ASR_DATA_CYC;
  // strobe stays low after data goes out for the longer of the two needs
  localparam integer HOLD_I = (DATA_I > WR_LOW_I - HIZ_I) ? DATA_I : WR_LOW_I - HIZ_I;
  localparam [`ASR_CNT_W-1:0] HIZ = to_cnt(HIZ_I);
  localparam [`ASR_CNT_W-1:0] HOLD = to_cnt(HOLD_I);
  localparam [`ASR_CNT_W-1:0] RD_WAIT = to_cnt(`ASR_RD_WAIT_CYC);
  localparam [`ASR_CNT_W-1:0] FILT = to_cnt(`ASR_FILT_CYC);

  // sequencer state and next values
  reg [5:0] state;
  reg [`ASR_CNT_W-1:0] cnt;
  reg [5:0] next_state;
  reg [`ASR_CNT_W-1:0] next_cnt;
  reg next_req_ready;
  reg next_rsp_valid;
  reg [`ASR_DATA_W-1:0] next_rsp_rdata;
  reg [`ASR_ADDR_W-1:0] next_addr_in;
  reg next_chip_select_n;
  reg next_write_strobe_n;
  reg next_output_enable_n;
  reg [`ASR_DATA_W-1:0] next_data_io_out;
  reg next_data_io_oe;
  wire [`ASR_DATA_W-1:0] data_sync;
  wire take;

  // request accepted at this edge
  assign take = req_valid && req_ready;

  // data pins pass the agreement filter before use
  asr_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pin(data_io_in),
    .value(data_sync)
  );

  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_req_ready = req_ready;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_addr_in = addr_in;
    next_chip_select_n = chip_select_n;
    next_write_strobe_n = write_strobe_n;
    next_output_enable_n = output_enable_n;
    next_data_io_out = data_io_out;
    next_data_io_oe = data_io_oe;
    case (state)
      ST_IDLE: begin
        next_chip_select_n = 1'b1;
        next_write_strobe_n = 1'b1;
        next_output_enable_n = 1'b1;
        // write data lingers one cycle past the strobe rise as hold
        next_data_io_oe = 1'b0;
        next_req_ready = 1'b1;
        if (take) begin
          next_req_ready = 1'b0;
          // address set up with select, a full cycle before the write strobe falls
          next_addr_in = req_addr;
          next_data_io_out = req_wdata;
          next_chip_select_n = 1'b0;
          if (req_write) begin
            // select leads the strobe; output enable stays high all write
            next_state = ST_WSET;
          end else begin
            next_output_enable_n = 1'b0;
            next_cnt = RD_WAIT;
            next_state = ST_RD;
          end
        end
      end
      ST_WSET: begin
        next_write_strobe_n = 1'b0;
        next_cnt = HIZ;
        next_state = ST_WLOW;
      end
      ST_WLOW: begin
        // drive data only after the memory has surely released
        if (cnt == ONE) begin
          next_data_io_oe = 1'b1;
          next_cnt = HOLD;
          next_state = ST_WEND;
        end else begin
          next_cnt = cnt_dec(cnt);
        end
      end
      ST_WEND: begin
        // strobe low and data valid long enough
        if (cnt == ONE) begin
          // select and strobe rise together: write ends, memory stays off
          next_write_strobe_n = 1'b1;
          next_chip_select_n = 1'b1;
          next_cnt = ZERO;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt_dec(cnt);
        end
      end
      ST_RD: begin
        // wait out access time, then the filter latency
        if (cnt == ZERO) begin
          next_cnt = FILT;
          next_state = ST_REND;
        end else begin
          next_cnt = cnt_dec(cnt);
        end
      end
      ST_REND: begin
        if (cnt == ZERO) begin
          next_rsp_rdata = data_sync;
          next_rsp_valid = 1'b1;
          // select and output enable rise together; strobe never moves in a read
          next_output_enable_n = 1'b1;
          next_chip_select_n = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt_dec(cnt);
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // every pin and answer leaves straight from a flop
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= ZERO;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 4'h0;
      addr_in <= 16'h0000;
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      data_io_out <= 4'h0;
      data_io_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      addr_in <= next_addr_in;
      chip_select_n <= next_chip_select_n;
      write_strobe_n <= next_write_strobe_n;
      output_enable_n <= next_output_enable_n;
      data_io_out <= next_data_io_out;
      data_io_oe <= next_data_io_oe;
    end
  end
endmodule // asr_host

// >>> sim/asr_host_asserts.sv
`timescale 1ns/1ps
`include "asr_consts.vh"
module asr_host_asserts (
  // clock and reset
  input wire clk,
  input wire srst,
  // pins
  input wire rsp_valid,
  input wire [`ASR_ADDR_W-1:0] addr_in,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_enable_n,
  input wire data_io_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wo; $fell(write_strobe_n); endsequence
  sequence s_wc; $rose(write_strobe_n) && $rose(chip_select_n); endsequence
  property p_rw; !output_enable_n |-> write_strobe_n; endproperty
  a_rw: assert property (p_rw) else $error("strobe in read");
  property p_bus; data_io_oe |-> output_enable_n; endproperty
  a_bus: assert property (p_bus) else $error("bus fight");
  property p_wa; !write_strobe_n |-> $stable(addr_in); endproperty
  a_wa: assert property (p_wa) else $error("addr moved");
  property p_ww; s_wo |=> !write_strobe_n; endproperty
  a_ww: assert property (p_ww) else $error("short strobe");
  property p_ws; s_wo |-> $past(chip_select_n) == 1'b0; endproperty
  a_ws: assert property (p_ws) else $error("late select");
  property p_we; s_wo |-> ##[2:8] s_wc; endproperty
  a_we: assert property (p_we) else $error("bad end");
  property p_wd; $rose(write_strobe_n) |-> $past(data_io_oe); endproperty
  a_wd: assert property (p_wd) else $error("no data");
  property p_ra; $fell(output_enable_n) |-> ##[4:20] rsp_valid; endproperty
  a_ra: assert property (p_ra) else $error("no answer");
endmodule // asr_host_asserts
bind asr_host asr_host_asserts u_chk (
  .clk(clk),
  .srst(srst),
  .rsp_valid(rsp_valid),
  .addr_in(addr_in),
  .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n),
  .data_io_oe(data_io_oe)
);

// >>> sim/asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model #(
  parameter int ACC_NS = 12
) (
  // pins
  input wire [15:0] addr_in,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_enable_n,
  input wire [3:0] data_io_out,
  input wire data_io_oe,
  // bus
  output wire [3:0] mem_q
);
  logic [3:0] mem [0:65535];
  logic [3:0] last = 4'h5;
  wire drv = !chip_select_n && write_strobe_n && !output_enable_n;
  // an undriven bus stores the wrong word, so a missing data drive shows on read-back
  always @(posedge (chip_select_n | write_strobe_n))
    mem[addr_in] <= data_io_oe ? data_io_out : ~data_io_out;
  // released bus shows the inverse, so a stale value never matches
  always @(negedge drv) last = ~mem_q;
  assign #(ACC_NS) mem_q = drv ? mem[addr_in] : last;
endmodule // asr_sram_model

// >>> sim/asr_host_tb_top.sv
`timescale 1ns/1ps
module asr_host_tb_top;
  logic clk = 0, srst = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid;
  logic [15:0] req_addr = 0, addr_in;
  logic [3:0] req_wdata = 0, rsp_rdata, data_io_out, mem_q;
  logic chip_select_n, write_strobe_n, output_enable_n, data_io_oe;
  wire [3:0] data_io_in = data_io_oe ? data_io_out : mem_q;
  logic [3:0] ref_mem [int];
  int error_cnt = 0, checks_done = 0, i;
  asr_host dut (.*);
  asr_sram_model u_mem (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 40) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic op(input logic w, input logic [15:0] a, input logic [3:0] d);
    int n;
    @(negedge clk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    for (n = 0; req_ready !== 1'b1; n++) begin
      tmo(n);
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 0;
    if (w) ref_mem[a] = d;
    for (n = 0; !w && rsp_valid !== 1'b1; n++) begin
      tmo(n);
      @(negedge clk);
    end
    if (!w) chk(rsp_rdata, ref_mem[a]);
  endtask
  initial begin
    i = $urandom(32'h2428);
    repeat (4) @(negedge clk);
    srst = 0;
    // first eight are writes so every read has a known word
    for (i = 0; i < 60; i++) begin
      op(i < 8 || $urandom % 2, i % 2 ? 16'hffff : 16'(i % 4), 4'($urandom));
      if (i == 29) begin
        // write cut by reset before its strobe falls: pins must return to idle
        op(1'b1, 16'h0000, ref_mem[0]);
        srst = 1;
        repeat (2) @(negedge clk);
        chk({chip_select_n, write_strobe_n, output_enable_n, data_io_oe}, 4'he);
        srst = 0;
      end
    end
    conclude();
  end
endmodule // asr_host_tb_top
